// ===== conv_seq_pkg.sv
package conv_seq_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int GAP_NS            = 350;  // least time between conversions
  localparam int START_PULSE_NS    = 250;  // least start strobe low time
  localparam int EARLY_READ_NS     = 250;  // start rise to early read fall
  localparam int READ_DONE_NS      = 150;  // read fall to done low
  localparam int DONE_TIMEOUT_NS   = 2000; // give-up wait for done or ready
  // least times round up
  localparam int GAP_CYC   = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EARLY_CYC = (EARLY_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RDONE_CYC = (READ_DONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TOUT_CYC  = DONE_TIMEOUT_NS / CLK_PERIOD_NS;

  localparam int CNT_W     = 8;
  localparam int DATA_W    = 8;
  localparam int HIST_AW   = 4;
  localparam int HIST_DEPTH = 16;

  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [HIST_AW-1:0] ADDR_ZERO = 4'h0;
  localparam logic [HIST_AW-1:0] ADDR_ONE  = 4'h1;

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic {
    single_read_mode = 1'b0,
    split_strobe_mode = 1'b1
  } mode_t;

  typedef enum logic [2:0] {
    st_idle, st_gap, st_start_low, st_start_wait, st_read_wait, st_read_low, st_finish
  } seq_state_t;

  // pins toward the converter
  typedef struct packed {
    logic              select_n;
    logic              read_n;
    logic              start_n;     // shared pin, driven only in split mode
    logic              start_oe;
    logic              mode_sel;
  } conv_pins_t;

  // result toward the user
  typedef struct packed {
    logic [DATA_W-1:0] code;
    logic              overrange;
    logic              timeout;
  } result_t;

endpackage

// ===== sample_hist_mem.sv
`timescale 1ns/10ps

// ------------------------------------------------------------------
// small history of recent samples, registered read data
// ------------------------------------------------------------------
module sample_hist_mem (
  input  wire logic                                  core_clk,
  input  wire logic                                  wr_en,
  input  wire logic [conv_seq_pkg::HIST_AW-1:0]      wr_addr,
  input  wire logic [conv_seq_pkg::DATA_W:0]         wr_data,
  input  wire logic [conv_seq_pkg::HIST_AW-1:0]      rd_addr,
  output logic      [conv_seq_pkg::DATA_W:0]         rd_data
);

  logic [conv_seq_pkg::DATA_W:0] mem [conv_seq_pkg::HIST_DEPTH];

  // no reset on storage; read data lag one cycle
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ===== conv_sequencer.sv
`timescale 1ns/10ps

// Operation
// - single mode: one long selected read converts
// - split mode: start strobe, then separate read
// - keep 350 ns gap between conversions
// - hold start strobe low 250 ns
// - early read 250 ns after start rise
// - 100 MHz clock: 250/250/150/350 ns timing
module conv_sequencer (
  input  wire logic                                core_clk,
  input  wire logic                                rstn,
  // user side
  input  wire logic                                conv_req,
  input  wire logic                                split_mode_req,
  input  wire logic                                early_read_req,
  input  wire logic [conv_seq_pkg::HIST_AW-1:0]    hist_addr,
  output logic                                     busy,
  output logic                                     result_valid,
  output conv_seq_pkg::result_t                    result,
  output logic      [conv_seq_pkg::DATA_W:0]       hist_data,
  // converter side
  output conv_seq_pkg::conv_pins_t                 pins,
  input  wire logic                                wait_request_in,
  input  wire logic                                conversion_done_n,
  input  wire logic                                overrange_flag_n,
  input  wire logic [conv_seq_pkg::DATA_W-1:0]     result_bus
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    conv_seq_pkg::seq_state_t          st;
    logic [conv_seq_pkg::CNT_W-1:0]    cnt;
    logic [conv_seq_pkg::CNT_W-1:0]    tout;
    logic                              split;
    logic                              early;
    logic                              busy;
    logic                              valid;
    conv_seq_pkg::result_t             res;
    conv_seq_pkg::conv_pins_t          pins;
    logic [conv_seq_pkg::HIST_AW-1:0]  wptr;
    logic                              hist_we;
  } seq_t;

  seq_t s_r;
  seq_t s_nxt;

  // ----------------------------------------------------------------
  // counter helpers
  // ----------------------------------------------------------------
  // saturating decrement, used by both counters
  function automatic logic [conv_seq_pkg::CNT_W-1:0] dec_sat(
    input logic [conv_seq_pkg::CNT_W-1:0] v
  );
    dec_sat = (v == conv_seq_pkg::CNT_ZERO) ? conv_seq_pkg::CNT_ZERO : v - conv_seq_pkg::CNT_ONE;
  endfunction

  // counter load from a cycle figure, cut to counter width
  function automatic logic [conv_seq_pkg::CNT_W-1:0] cyc(input int n);
    cyc = conv_seq_pkg::CNT_W'(n);
  endfunction

  // a counter that has run down to zero ends the step it times
  function automatic logic run_out(input logic [conv_seq_pkg::CNT_W-1:0] v);
    run_out = (v == conv_seq_pkg::CNT_ZERO);
  endfunction

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  // one step per state; both counters run down on every cycle that does not load them
  always_comb begin
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.hist_we = 1'b0;
    s_nxt.cnt = dec_sat(s_r.cnt);
    s_nxt.tout = dec_sat(s_r.tout);
    case (s_r.st)
      conv_seq_pkg::st_idle: begin
        // gap counter keeps running here so back-to-back requests still wait
        if (conv_req) begin
          s_nxt.split = split_mode_req;
          s_nxt.early = early_read_req;
          s_nxt.busy  = 1'b1;
          s_nxt.pins.mode_sel = split_mode_req;
          s_nxt.st = conv_seq_pkg::st_gap;
        end
      end
      conv_seq_pkg::st_gap: begin
        // mode pin settles one cycle before any strobe; gap enforced too
        // select and strobe fall together, which the converter accepts
        if (run_out(s_r.cnt)) begin
          s_nxt.pins.select_n = 1'b0;
          s_nxt.tout = cyc(conv_seq_pkg::TOUT_CYC);
          if (s_r.split) begin
            s_nxt.pins.start_n = 1'b0;
            s_nxt.cnt = cyc(conv_seq_pkg::PULSE_CYC);
            s_nxt.st = conv_seq_pkg::st_start_low;
          end else begin
            s_nxt.pins.read_n = 1'b0;
            s_nxt.cnt = cyc(conv_seq_pkg::RDONE_CYC);
            s_nxt.st = conv_seq_pkg::st_read_wait;
          end
        end
      end
      conv_seq_pkg::st_start_low: begin
        if (run_out(s_r.cnt)) begin
          s_nxt.pins.start_n = 1'b1;
          s_nxt.cnt = cyc(conv_seq_pkg::EARLY_CYC);
          s_nxt.st = conv_seq_pkg::st_start_wait;
        end
      end
      conv_seq_pkg::st_start_wait: begin
        // early read skips the done flag; else wait for done low
        // the timeout keeps a dead converter from hanging the user side
        if ((s_r.early && run_out(s_r.cnt)) || !conversion_done_n) begin
          s_nxt.pins.read_n = 1'b0;
          s_nxt.cnt = cyc(conv_seq_pkg::RDONE_CYC);
          s_nxt.st = conv_seq_pkg::st_read_low;
        end else if (run_out(s_r.tout)) begin
          s_nxt.res.timeout = 1'b1;
          s_nxt.st = conv_seq_pkg::st_finish;
        end
      end
      conv_seq_pkg::st_read_wait: begin
        // single mode: ready held low by converter until conversion ends
        // first cycles skipped: ready needs time to pull low after select
        if (run_out(s_r.cnt) && wait_request_in) begin
          s_nxt.cnt = cyc(conv_seq_pkg::RDONE_CYC);
          s_nxt.st = conv_seq_pkg::st_read_low;
        end else if (run_out(s_r.tout)) begin
          s_nxt.res.timeout = 1'b1;
          s_nxt.st = conv_seq_pkg::st_finish;
        end
      end
      conv_seq_pkg::st_read_low: begin
        // bus given access time before sampling; overrange is always driven
        if (run_out(s_r.cnt)) begin
          s_nxt.res.code = result_bus;
          s_nxt.res.overrange = !overrange_flag_n;
          s_nxt.res.timeout = 1'b0;
          s_nxt.st = conv_seq_pkg::st_finish;
        end
      end
      conv_seq_pkg::st_finish: begin
        // rising select and read clear done; bus released
        // gap count starts here, so the next select waits out the gap
        s_nxt.pins.read_n = 1'b1;
        s_nxt.pins.select_n = 1'b1;
        s_nxt.valid = 1'b1;
        s_nxt.hist_we = !s_r.res.timeout;
        s_nxt.busy = 1'b0;
        s_nxt.cnt = cyc(conv_seq_pkg::GAP_CYC);
        s_nxt.st = conv_seq_pkg::st_idle;
      end
      default: begin
        // unused encodings: release every strobe and fall back to idle
        s_nxt.pins.start_n = 1'b1;
        s_nxt.pins.read_n = 1'b1;
        s_nxt.pins.select_n = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.st = conv_seq_pkg::st_idle;
      end
    endcase
    // the converter owns the shared pin in single mode, so let go there
    s_nxt.pins.start_oe = s_nxt.pins.mode_sel; // shared pin is ours only in split mode
    if (s_r.hist_we) begin
      s_nxt.wptr = s_r.wptr + conv_seq_pkg::ADDR_ONE;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '{st: conv_seq_pkg::st_idle, cnt: conv_seq_pkg::CNT_ZERO,
               tout: conv_seq_pkg::CNT_ZERO, split: 1'b0, early: 1'b0, busy: 1'b0,
               valid: 1'b0, res: '0,
               pins: '{select_n: 1'b1, read_n: 1'b1, start_n: 1'b1,
                       start_oe: 1'b0, mode_sel: 1'b0},
               wptr: conv_seq_pkg::ADDR_ZERO, hist_we: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs and history
  // ----------------------------------------------------------------
  // plain copies of the state register, no logic after the flip-flops
  assign busy         = s_r.busy;
  assign result_valid = s_r.valid;
  assign result       = s_r.res;
  assign pins         = s_r.pins;

  sample_hist_mem u_hist (
    .core_clk (core_clk),
    .wr_en    (s_r.hist_we),
    .wr_addr  (s_r.wptr),
    .wr_data  ({s_r.res.overrange, s_r.res.code}),
    .rd_addr  (hist_addr),
    .rd_data  (hist_data)
  );

endmodule

// ===== conv_sequencer_properties.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// strobe timing, pin and completion checks
// ----------------------------------------------------------------
module conv_sequencer_chk (
  input wire logic                     core_clk,
  input wire logic                     rstn,
  input wire logic                     conv_req,
  input wire logic                     split_mode_req,
  input wire logic                     busy,
  input wire logic                     result_valid,
  input wire conv_seq_pkg::conv_pins_t pins,
  input wire logic                     wait_request_in
);
  logic [7:0] low_r;
  logic [7:0] high_r;
  logic [7:0] gap_r;
  // high_r and gap_r saturate; low_r wraps, since a start pulse cannot reach that width
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      low_r  <= 8'h00;
      high_r <= 8'h00;
      gap_r  <= 8'hff;
    end else begin
      low_r  <= (pins.start_oe && !pins.start_n) ? low_r + 8'h01 : 8'h00;
      high_r <= (pins.start_oe && !pins.start_n) ? 8'h00 : high_r + {7'h00, high_r != 8'hff};
      gap_r  <= !pins.select_n ? 8'h00 : gap_r + {7'h00, gap_r != 8'hff};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  sequence s_req;
    conv_req && !busy;
  endsequence
  sequence s_single_rd;
    $fell(pins.read_n) && !pins.mode_sel;
  endsequence
  pulse_width_a: assert property ($rose(pins.start_n) && pins.start_oe |->
    low_r >= conv_seq_pkg::PULSE_CYC) else $error("start strobe too short");
  conv_gap_a: assert property ($fell(pins.select_n) |->
    gap_r >= conv_seq_pkg::GAP_CYC) else $error("gap between conversions too short");
  early_read_a: assert property ($fell(pins.read_n) && pins.mode_sel |->
    high_r >= conv_seq_pkg::EARLY_CYC) else $error("read too soon after start");
  mode_pin_a: assert property (s_req |-> ##[1:2] pins.mode_sel == split_mode_req)
    else $error("mode pin wrong");
  single_read_a: assert property (s_single_rd |-> !pins.select_n)
    else $error("read without select");
  ready_hold_a: assert property (!pins.mode_sel && !pins.read_n && !wait_request_in |=>
    !pins.read_n) else $error("read released while converter busy");
  start_sel_a: assert property ($fell(pins.start_n) && pins.start_oe |->
    !pins.select_n && pins.read_n) else $error("start without select");
  shared_pin_a: assert property (pins.start_oe |-> pins.mode_sel)
    else $error("shared pin driven in single mode");
  mode_stable_a: assert property ($changed(pins.mode_sel) |-> pins.select_n && pins.read_n)
    else $error("mode pin moved during a selected cycle");
  conv_done_a: assert property ($rose(busy) |-> ##[1:400] result_valid)
    else $error("conversion never finished");
endmodule

bind conv_sequencer conv_sequencer_chk u_chk (.core_clk, .rstn, .conv_req, .split_mode_req,
  .busy, .result_valid, .pins, .wait_request_in);

// ===== conv_dev_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// behavioural converter, clockless, delays in ns
// ----------------------------------------------------------------
module conv_dev_model #(parameter int CONV_NS = 600) (
  input  wire logic       select_n,
  input  wire logic       read_n,
  input  wire logic       start_n,
  input  wire logic       start_oe,
  input  wire logic       mode_sel,
  input  wire logic       mute,
  input  wire logic [8:0] sample,
  output logic            done_n = 1'b1,
  output logic            ofl_n = 1'b1,
  output logic            rdy_pull = 1'b0,
  output logic [7:0]      result_bus
);
  logic [8:0] held = 9'h000;
  logic [3:0] upper = 4'h0;
  logic [7:0] out_r = 8'h00;
  logic       busy_c = 1'b0;
  // input tracked between conversions, frozen on the start edge
  // the short wait lets select settle when both pins fall in one step
  always @(negedge start_n) begin
    #0.1;
    if (start_oe && mode_sel && !select_n) held = sample;
  end
  always @(posedge start_n) if (start_oe && mode_sel && !select_n) begin
    upper = held[7:4];
    busy_c = 1'b1;
    #380;
    if (busy_c) begin
      out_r = {upper, held[3:0]};
      ofl_n = ~held[8];
      busy_c = 1'b0;
      if (!mute) done_n = 1'b0;
    end
  end
  always @(negedge read_n) begin
    #0.1;
    if (!select_n) begin
      if (mode_sel && busy_c) begin
        out_r = {upper, held[3:0]};
        ofl_n = ~held[8];
        busy_c = 1'b0;
        #150 done_n = 1'b0;
      end else if (!mode_sel) begin
        held = sample;
        rdy_pull = 1'b1;
        #CONV_NS;
        out_r = held[7:0];
        ofl_n = ~held[8];
        rdy_pull = 1'b0;
        done_n = 1'b0;
      end
    end
  end
  always @(posedge select_n or posedge read_n) done_n = 1'b1;
  // a released bus shows inverted data so a late sample cannot match by luck
  assign result_bus = (!select_n && !read_n) ? out_r : ~out_r;
endmodule

// ===== conv_sequencer_tb_top.sv
`timescale 1ns/10ps
module conv_sequencer_tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic conv_req = 1'b0;
  logic split_mode_req = 1'b0;
  logic early_read_req = 1'b0;
  logic mute = 1'b0;
  logic [3:0] hist_addr = 4'h0;
  logic [8:0] sample = 9'h000;
  logic busy, result_valid, done_n, ofl_n, rdy_pull;
  logic [8:0] hist_data;
  logic [7:0] result_bus;
  conv_seq_pkg::result_t result;
  conv_seq_pkg::conv_pins_t pins;
  int errors = 0;
  int n_tests = 0;
  // shared pin: ours in split mode, pulled up unless the converter holds it low
  wire wait_w = pins.start_oe ? pins.start_n : !rdy_pull;
  initial forever #5 core_clk = ~core_clk;
  conv_sequencer DUT (.core_clk, .rstn, .conv_req, .split_mode_req, .early_read_req,
    .hist_addr, .busy, .result_valid, .result, .hist_data, .pins, .wait_request_in(wait_w),
    .conversion_done_n(done_n), .overrange_flag_n(ofl_n), .result_bus);
  conv_dev_model CONV (.select_n(pins.select_n), .read_n(pins.read_n), .start_n(pins.start_n),
    .start_oe(pins.start_oe), .mode_sel(pins.mode_sel), .mute, .sample, .done_n, .ofl_n,
    .rdy_pull, .result_bus);
  task automatic chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out;
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one request, then a bounded wait for the result pulse
  task automatic convert(input logic split, input logic early, input logic [8:0] smp);
    int i;
    @(negedge core_clk);
    sample = smp;
    split_mode_req = split;
    early_read_req = early;
    conv_req = 1'b1;
    @(negedge core_clk);
    conv_req = 1'b0;
    chk("busy", {8'h00, busy}, 9'h001);
    for (i = 0; i < 500 && result_valid !== 1'b1; i++) @(negedge core_clk);
    if (i == 500) begin
      errors++;
      close_out();
    end
    chk("busy done", {8'h00, busy}, 9'h000);
  endtask
  // history holds good samples in order; the timed-out attempt is not stored
  task automatic hist_check;
    logic [8:0] h [7] = '{9'h05a, 9'h1ff, 9'h0f0, 9'h000, 9'h0ff, 9'h180, 9'h0c3};
    foreach (h[k]) begin
      @(negedge core_clk);
      hist_addr = 4'(k);
      @(negedge core_clk);
      chk("history", hist_data, h[k]);
    end
  endtask
  task automatic split_wait;
    convert(1'b1, 1'b0, 9'h05a);
    chk("split code", {result.overrange, result.code}, 9'h05a);
  endtask
  // early reads back to back, first one overrange
  task automatic split_early;
    convert(1'b1, 1'b1, 9'h1ff);
    chk("early code", {result.overrange, result.code}, 9'h1ff);
    convert(1'b1, 1'b1, 9'h0f0);
    chk("early code", {result.overrange, result.code}, 9'h0f0);
  endtask
  task automatic single_bounds;
    logic [8:0] v [3] = '{9'h000, 9'h0ff, 9'h180};
    foreach (v[k]) begin
      convert(1'b0, 1'b0, v[k]);
      chk("single code", {result.overrange, result.code}, v[k]);
    end
  endtask
  // converter never signals done: the sequencer must give up, then recover
  task automatic lost_done;
    mute = 1'b1;
    convert(1'b1, 1'b0, 9'h033);
    chk("timeout", {8'h00, result.timeout}, 9'h001);
    mute = 1'b0;
    convert(1'b1, 1'b0, 9'h0c3);
    chk("recovered", {result.timeout, result.code}, 9'h0c3);
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    split_wait();
    split_early();
    single_bounds();
    lost_done();
    hist_check();
    close_out();
  end
endmodule
